// ==== rtrc_run_control.sv ====
// AHB-Lite register slave and run gating for two remote terminals
`timescale 1ns/1ns
module rtrc_run_control (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire rtrc_pkg::rtrc_ahb_req_t ahbReq,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic firstTerminalEnablePin,
	input wire logic secondTerminalEnablePin,
	output logic firstTerminalActive,
	output logic secondTerminalActive
);
	import rtrc_pkg::*;

	rtrc_state_t st;
	rtrc_state_t next_st;

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic addrIs(input logic [31:0] a, input logic [11:0] off);
		return a[RTRC_DEC_BITS-1:0] == off;
	endfunction

	// Effective enable: stored bit gated by the pin
	function automatic logic enabledGate(input logic enable, input logic pin);
		return enable & pin;
	endfunction

	// Run output: effective enable and start bit
	function automatic logic runGate(input logic enable, input logic pin, input logic run);
		return enabledGate(enable, pin) & run;
	endfunction

	function automatic logic [31:0] readValue(input logic [31:0] a, input rtrc_cfg_t c,
			input logic fa, input logic sa, input logic fp, input logic sp);
		logic [31:0] v;
		v = 32'h0000_0000;
		if (addrIs(a, RTRC_CFG_OFF)) begin
			v[RTRC_SECOND_ENABLE_BIT] = c.secondTerminalEnable;
			v[RTRC_FIRST_ENABLE_BIT] = c.firstTerminalEnable;
			v[RTRC_SECOND_RUN_BIT] = c.secondTerminalRun;
			v[RTRC_FIRST_RUN_BIT] = c.firstTerminalRun;
		end else if (addrIs(a, RTRC_STAT_OFF)) begin
			v[RTRC_ST_FIRST_ACTIVE_BIT] = fa;
			v[RTRC_ST_SECOND_ACTIVE_BIT] = sa;
			v[RTRC_ST_FIRST_PIN_BIT] = fp;
			v[RTRC_ST_SECOND_PIN_BIT] = sp;
			v[RTRC_ST_FIRST_ENABLED_BIT] = enabledGate(c.firstTerminalEnable, fp);
			v[RTRC_ST_SECOND_ENABLED_BIT] = enabledGate(c.secondTerminalEnable, sp);
		end
		return v;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	logic take;
	assign take = ahbReq.hsel & ahbReq.htrans[1] & ahbReq.hready;

	always_comb begin
		next_st = st;
		next_st.wrPend = 1'b0;
		next_st.readyOut = 1'b1;
		next_st.respErr = 1'b0;
		// Write data phase lands here
		if (st.wrPend && st.wrCfg) begin
			// Set request ignored while the pin is low
			next_st.cfg.secondTerminalEnable = hwdata[RTRC_SECOND_ENABLE_BIT]
				& secondTerminalEnablePin;
			next_st.cfg.firstTerminalEnable = hwdata[RTRC_FIRST_ENABLE_BIT]
				& firstTerminalEnablePin;
			next_st.cfg.secondTerminalRun = hwdata[RTRC_SECOND_RUN_BIT];
			next_st.cfg.firstTerminalRun = hwdata[RTRC_FIRST_RUN_BIT];
		end
		if (take && ahbReq.hwrite) begin
			next_st.wrPend = 1'b1;
			next_st.wrCfg = addrIs(ahbReq.haddr, RTRC_CFG_OFF);
		end
		// Read sees the control bits of a write finishing at the same edge, so no wait state
		if (take && !ahbReq.hwrite) begin
			next_st.rdata = readValue(ahbReq.haddr, next_st.cfg, st.firstActive,
				st.secondActive, firstTerminalEnablePin, secondTerminalEnablePin);
		end
		// Losing any term drops the run output at the next edge
		next_st.secondActive = runGate(next_st.cfg.secondTerminalEnable, secondTerminalEnablePin,
			next_st.cfg.secondTerminalRun);
		next_st.firstActive = runGate(next_st.cfg.firstTerminalEnable, firstTerminalEnablePin,
			next_st.cfg.firstTerminalRun);
		if (!ce) begin
			next_st = st;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st.cfg <= RTRC_CFG_RESET;
			st.wrPend <= 1'b0;
			st.wrCfg <= 1'b0;
			st.readyOut <= 1'b1;
			st.respErr <= 1'b0;
			st.rdata <= RTRC_RDATA_RESET;
			st.firstActive <= 1'b0;
			st.secondActive <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	assign hrdata = st.rdata;
	assign hreadyout = st.readyOut;
	assign hresp = st.respErr;
	assign firstTerminalActive = st.firstActive;
	assign secondTerminalActive = st.secondActive;

	////////////////////////////////////////////////////////////////////////////////
	AST_SECOND_GATE: assert property (@(posedge clk) disable iff (rst)
		(ce && !st.wrPend && !(st.cfg.secondTerminalEnable && secondTerminalEnablePin))
		|=> !secondTerminalActive)
		else $error("Second terminal ran without enable and pin");

	AST_FIRST_GATE: assert property (@(posedge clk) disable iff (rst)
		(ce && !st.wrPend && !(st.cfg.firstTerminalEnable && firstTerminalEnablePin))
		|=> !firstTerminalActive)
		else $error("First terminal ran without enable and pin");

	AST_ENABLE_BLOCKED: assert property (@(posedge clk) disable iff (rst)
		(ce && !firstTerminalEnablePin && !st.cfg.firstTerminalEnable)
		|=> !st.cfg.firstTerminalEnable)
		else $error("Enable bit set while pin low");

	AST_NEEDS_START: assert property (@(posedge clk) disable iff (rst)
		(ce && !st.wrPend && st.cfg.secondTerminalEnable && !st.cfg.secondTerminalRun)
		|=> !secondTerminalActive)
		else $error("Enabled terminal ran without start bit");

	AST_PIN_HALT: assert property (@(posedge clk) disable iff (rst)
		(ce && secondTerminalActive && !secondTerminalEnablePin)
		|=> !secondTerminalActive)
		else $error("Terminal not halted after pin fell");

	AST_SECOND_START: assert property (@(posedge clk) disable iff (rst)
		(ce && !st.wrPend && st.cfg.secondTerminalEnable && secondTerminalEnablePin
		&& st.cfg.secondTerminalRun) |=> secondTerminalActive)
		else $error("Second terminal did not start");

	AST_FIRST_START: assert property (@(posedge clk) disable iff (rst)
		(ce && !st.wrPend && st.cfg.firstTerminalEnable && firstTerminalEnablePin
		&& st.cfg.firstTerminalRun) |=> firstTerminalActive)
		else $error("First terminal did not start");

	AST_RESET_CLEAR: assert property (@(posedge clk)
		rst |=> (st.cfg == RTRC_CFG_RESET && !firstTerminalActive && !secondTerminalActive))
		else $error("Control bits not clear after reset");

	// Data phase, start bit, pin and readback checks: hwdata only means something while wrPend is high
	AST_SECOND_ENABLE_BLOCKED: assert property (@(posedge clk) disable iff (rst)
		(ce && st.wrPend && st.wrCfg && !secondTerminalEnablePin)
		|=> !st.cfg.secondTerminalEnable)
		else $error("Second enable bit set while pin low");

	AST_FIRST_NEEDS_START: assert property (@(posedge clk) disable iff (rst)
		(ce && !st.wrPend && st.cfg.firstTerminalEnable && !st.cfg.firstTerminalRun)
		|=> !firstTerminalActive)
		else $error("Enabled first terminal ran without start bit");

	AST_FIRST_PIN_HALT: assert property (@(posedge clk) disable iff (rst)
		(ce && firstTerminalActive && !firstTerminalEnablePin)
		|=> !firstTerminalActive)
		else $error("First terminal not halted after pin fell");

	AST_SECOND_BIT_HALT: assert property (@(posedge clk) disable iff (rst)
		(ce && st.wrPend && st.wrCfg && !hwdata[RTRC_SECOND_ENABLE_BIT])
		|=> !secondTerminalActive)
		else $error("Second terminal not halted after enable bit cleared");

	AST_FIRST_BIT_HALT: assert property (@(posedge clk) disable iff (rst)
		(ce && st.wrPend && st.wrCfg && !hwdata[RTRC_FIRST_ENABLE_BIT])
		|=> !firstTerminalActive)
		else $error("First terminal not halted after enable bit cleared");

	AST_SECOND_STOP: assert property (@(posedge clk) disable iff (rst)
		(ce && st.wrPend && st.wrCfg && !hwdata[RTRC_SECOND_RUN_BIT])
		|=> !secondTerminalActive)
		else $error("Second terminal not stopped by start bit");

	AST_FIRST_STOP: assert property (@(posedge clk) disable iff (rst)
		(ce && st.wrPend && st.wrCfg && !hwdata[RTRC_FIRST_RUN_BIT])
		|=> !firstTerminalActive)
		else $error("First terminal not stopped by start bit");

	AST_RUN_BITS_WRITTEN: assert property (@(posedge clk) disable iff (rst)
		(ce && st.wrPend && st.wrCfg && hwdata[RTRC_SECOND_RUN_BIT] && hwdata[RTRC_FIRST_RUN_BIT])
		|=> (st.cfg.secondTerminalRun && st.cfg.firstTerminalRun))
		else $error("Start bits not stored by write");

	AST_FIRST_ENABLE_STORED: assert property (@(posedge clk) disable iff (rst)
		(ce && st.wrPend && st.wrCfg && hwdata[RTRC_FIRST_ENABLE_BIT] && firstTerminalEnablePin)
		|=> st.cfg.firstTerminalEnable)
		else $error("First enable bit not stored with pin high");

	AST_SECOND_ENABLE_STORED: assert property (@(posedge clk) disable iff (rst)
		(ce && st.wrPend && st.wrCfg && hwdata[RTRC_SECOND_ENABLE_BIT] && secondTerminalEnablePin)
		|=> st.cfg.secondTerminalEnable)
		else $error("Second enable bit not stored with pin high");

	AST_WRITE_ELSEWHERE: assert property (@(posedge clk) disable iff (rst)
		(ce && st.wrPend && !st.wrCfg)
		|=> (st.cfg == $past(st.cfg)))
		else $error("Control bits changed by write to another offset");

	AST_CFG_READBACK: assert property (@(posedge clk) disable iff (rst)
		(ce && take && !ahbReq.hwrite && addrIs(ahbReq.haddr, RTRC_CFG_OFF) && !st.wrPend)
		|=> (hrdata[RTRC_SECOND_ENABLE_BIT:RTRC_FIRST_RUN_BIT] == st.cfg))
		else $error("Control read data differs from control bits");

	AST_STATUS_READBACK: assert property (@(posedge clk) disable iff (rst)
		(ce && take && !ahbReq.hwrite && addrIs(ahbReq.haddr, RTRC_STAT_OFF))
		|=> (hrdata[RTRC_ST_FIRST_ACTIVE_BIT] == $past(firstTerminalActive)
		&& hrdata[RTRC_ST_SECOND_ACTIVE_BIT] == $past(secondTerminalActive)))
		else $error("Status read data differs from run outputs");

endmodule // rtrc_run_control

// ==== rtrc_pkg.sv ====
// Constants and types for the remote terminal run control block
package rtrc_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register map, word aligned
	localparam logic [11:0] RTRC_CFG_OFF = 12'h000;
	localparam logic [11:0] RTRC_STAT_OFF = 12'h004;
	localparam int RTRC_DEC_BITS = 12;

	// Control register bit positions
	localparam int RTRC_SECOND_ENABLE_BIT = 7;
	localparam int RTRC_FIRST_ENABLE_BIT = 6;
	localparam int RTRC_SECOND_RUN_BIT = 5;
	localparam int RTRC_FIRST_RUN_BIT = 4;

	// Status register bit positions
	localparam int RTRC_ST_FIRST_ACTIVE_BIT = 0;
	localparam int RTRC_ST_SECOND_ACTIVE_BIT = 1;
	localparam int RTRC_ST_FIRST_PIN_BIT = 2;
	localparam int RTRC_ST_SECOND_PIN_BIT = 3;
	localparam int RTRC_ST_FIRST_ENABLED_BIT = 4;
	localparam int RTRC_ST_SECOND_ENABLED_BIT = 5;

	// Reset values
	localparam logic [3:0] RTRC_CFG_RESET = 4'h0;
	localparam logic [31:0] RTRC_RDATA_RESET = 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic hsel;
		logic [31:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic hready;
	} rtrc_ahb_req_t;

	typedef struct packed {
		logic secondTerminalEnable;
		logic firstTerminalEnable;
		logic secondTerminalRun;
		logic firstTerminalRun;
	} rtrc_cfg_t;

	typedef struct packed {
		rtrc_cfg_t cfg;
		logic wrPend;
		logic wrCfg;
		logic readyOut;
		logic respErr;
		logic [31:0] rdata;
		logic firstActive;
		logic secondActive;
	} rtrc_state_t;

endpackage

// ==== rtrc_host_model.sv ====
// Host model: AHB-Lite single-word master for the run control registers
`timescale 1ns/1ns
module rtrc_host_model (
	input wire logic clk,
	output rtrc_pkg::rtrc_ahb_req_t ahbReq,
	output logic [31:0] hwdata,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout
);
	import rtrc_pkg::*;
	rtrc_ahb_req_t req = '0;
	initial hwdata = 32'h0;
	// Single slave, so its ready is the bus ready
	assign ahbReq = {req.hsel, req.haddr, req.htrans, req.hwrite, req.hsize, hreadyout};
	////////////////////////////////////////////////////////////////////////////////
	// Call just after a rising edge; returns at the data phase end edge
	task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
			output logic [31:0] rd);
		req.hsel <= 1'b1;
		req.haddr <= {20'h0, addr};
		req.htrans <= 2'h2;
		req.hwrite <= wr;
		req.hsize <= 3'h2;
		do @(posedge clk); while (hreadyout !== 1'b1);
		req.htrans <= 2'h0;
		req.hsel <= 1'b0;
		hwdata <= wd;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
endmodule // rtrc_host_model

// ==== rtrc_run_control_test.sv ====
// Self-checking bench for the remote terminal run control block
`timescale 1ns/1ns
module rtrc_run_control_test;
	import rtrc_pkg::*;
	logic clk = 1'b0, rst = 1'b1, pin1 = 1'b0, pin2 = 1'b0, clkEn = 1'b1;
	logic act1, act2, rdy, resp;
	logic [31:0] hwdata, hrdata, rd;
	rtrc_ahb_req_t ahbReq;
	int mismatches = 0, numChecks = 0;
	logic [7:0] vals [6] = '{8'hf0, 8'hb0, 8'h70, 8'hc0, 8'hd0, 8'he0};
	rtrc_run_control rtrc_run_control_inst (.clk(clk), .rst(rst), .ce(clkEn), .ahbReq(ahbReq),
		.hwdata(hwdata), .hrdata(hrdata), .hreadyout(rdy), .hresp(resp),
		.firstTerminalEnablePin(pin1), .secondTerminalEnablePin(pin2),
		.firstTerminalActive(act1), .secondTerminalActive(act2));
	rtrc_host_model rtrc_host_model_inst (.clk(clk), .ahbReq(ahbReq), .hwdata(hwdata),
		.hrdata(hrdata), .hreadyout(rdy));
	initial forever #2 clk = ~clk;
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		numChecks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		rtrc_host_model_inst.xfer(1'b1, a, d, rd);
		// One more edge: run outputs then show the landed write, next call stays edge aligned
		@(posedge clk);
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
		rtrc_host_model_inst.xfer(1'b0, a, 32'h0, rd);
		chk("register", exp, rd);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", numChecks, mismatches);
		if (mismatches == 0 && numChecks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (2000) @(posedge clk);
		mismatches++;
		print_verdict();
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rdchk(RTRC_CFG_OFF, 32'h0);
		// Pins low: enable bits refuse to set, nothing runs
		wr(RTRC_CFG_OFF, 32'hf0);
		chk("actives", 2'b00, {act2, act1});
		rdchk(RTRC_CFG_OFF, 32'h30);
		@(posedge clk);
		pin1 <= 1'b1;
		pin2 <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 6; i++) begin
			wr(RTRC_CFG_OFF, {24'h0, vals[i]});
			chk("actives", {vals[i][7] & vals[i][5], vals[i][6] & vals[i][4]}, {act2, act1});
			rdchk(RTRC_CFG_OFF, {24'h0, vals[i]});
		end
		wr(RTRC_CFG_OFF, 32'hf0);
		rdchk(RTRC_STAT_OFF, 32'h3f);
		// Drop one pin mid-run: that terminal halts at the next edge
		pin1 <= 1'b0;
		repeat (2) @(posedge clk);
		chk("actives", 2'b10, {act2, act1});
		pin2 <= 1'b0;
		repeat (2) @(posedge clk);
		chk("actives", 2'b00, {act2, act1});
		// Stored enables survive the pins, so both resume with them
		pin1 <= 1'b1;
		pin2 <= 1'b1;
		repeat (2) @(posedge clk);
		chk("actives", 2'b11, {act2, act1});
		// Clock enable low freezes the run outputs
		clkEn <= 1'b0;
		pin1 <= 1'b0;
		repeat (2) @(posedge clk);
		chk("frozen", 2'b11, {act2, act1});
		clkEn <= 1'b1;
		repeat (2) @(posedge clk);
		chk("actives", 2'b10, {act2, act1});
		// Clearing only the second start bit stops a running second terminal
		pin1 <= 1'b1;
		wr(RTRC_CFG_OFF, 32'hd0);
		chk("actives", 2'b01, {act2, act1});
		wr(RTRC_STAT_OFF, 32'h0);
		rdchk(RTRC_CFG_OFF, 32'hd0);
		chk("hresp", 32'h0, resp);
		print_verdict();
	end
endmodule // rtrc_run_control_test
